/* bench/ats_backend_model.sv */
`timescale 1ns/1ps
// Back end stand-in: each command ends seven cycles after it starts.
module ats_backend_model (
   input wire ref_clk,
   input wire reset_n,
   input wire cmd_start,
   input wire fail_en,
   output wire cmd_done,
   output wire cmd_fail,
   output wire [15:0] cmd_left
);
   reg [3:0] cnt; // Cycles left; zero while idle.
   always @(posedge ref_clk)
      cnt <= !reset_n ? 4'h0 : cmd_start ? 4'h7 : cnt - {3'h0, |cnt};
   assign cmd_done = cnt == 4'h1;
   assign cmd_fail = fail_en & cmd_done;
   // The count is only valid with done, so show junk at other times.
   assign cmd_left = cmd_done ? 16'h0003 : 16'hFFFC;
endmodule

/* bench/ats_chk.sv */
`timescale 1ns/1ps
// Port checker for the task-file block.
module ats_chk (
   input wire ref_clk,
   input wire reset_n,
   input wire host_wr,
   input wire host_rd,
   input wire [3:0] host_addr,
   input wire [7:0] host_wdata,
   input wire [7:0] host_rdata,
   input wire host_interrupt,
   input wire cmd_start,
   input wire [7:0] cmd_opcode,
   input wire cmd_done,
   input wire user_pw_saved,
   input wire sec_locked
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // A status read; its answer shows one cycle later.
   sequence s_st_rd;
      host_rd && (host_addr == 4'h7 || host_addr == 4'hE);
   endsequence
   a_start_cause: assert property (cmd_start |-> $past(host_wr) &&
      $past(host_addr) == 4'h7) else $error("start without write");
   a_start_opcode: assert property (cmd_start |->
      cmd_opcode == $past(host_wdata)) else $error("wrong opcode");
   a_locked_refuse: assert property (host_wr && host_addr == 4'h7 &&
      sec_locked && host_wdata == 8'h20 |=> !cmd_start) else $error("locked");
   a_bad_opcode: assert property (host_wr && host_addr == 4'h7 &&
      host_wdata == 8'h01 |=> !cmd_start) else $error("bad opcode started");
   a_ack_clear: assert property (s_st_rd ##0 (host_addr == 4'h7 &&
      !cmd_done) |=> !host_interrupt) else $error("interrupt kept");
   a_busy_mask: assert property (s_st_rd |=> !host_rdata[7] ||
      host_rdata[6:0] == 7'h00) else $error("busy flags shown");
   a_corrected_zero: assert property (s_st_rd |=> !host_rdata[2])
      else $error("corrected set");
   a_lock_reset: assert property ($rose(reset_n) |=>
      sec_locked == $past(user_pw_saved)) else $error("lock state");
endmodule

/* bench/test_ats_task_file.sv */
`timescale 1ns/1ps
// Host-side register calls with expected values.
module test_ats_task_file;
   reg ref_clk = 1'b0, reset_n = 1'b0, host_wr = 1'b0, host_rd = 1'b0;
   reg init_done = 1'b0, write_fault = 1'b0, seek_begin = 1'b0;
   reg seek_end = 1'b0, index_mark = 1'b0, pw_we = 1'b0, fail_en = 1'b0;
   reg user_pw_saved = 1'b0, started = 1'b0;
   reg power_save = 1'b0, xfer_ready = 1'b0;
   reg [3:0] host_addr = 4'h0;
   reg [4:0] pw_index = 5'h00;
   reg [7:0] host_wdata = 8'h00, d;
   reg [15:0] pw_word = 16'h0000;
   wire [7:0] host_rdata, cmd_feature;
   wire [16:0] cmd_sectors;
   wire [15:0] cmd_left;
   wire host_interrupt, cmd_start, cmd_done, cmd_fail, sec_locked;
   integer fail_count = 0, total_checks = 0, cycles = 0, i, p;
   ats_task_file ats_task_file_inst (.ref_clk, .reset_n, .host_wr, .host_rd,
      .host_addr, .host_wdata, .host_rdata, .host_interrupt, .cmd_start,
      .cmd_opcode(), .cmd_feature, .cmd_sectors, .cmd_done, .cmd_fail,
      .cmd_left, .init_done, .write_fault, .seek_begin, .seek_end,
      .power_save, .xfer_ready, .index_mark, .pw_we, .pw_index,
      .pw_word, .user_pw_saved, .user_pw_store(), .sec_locked);
   ats_backend_model ats_backend_model_inst (.ref_clk, .reset_n,
      .cmd_start, .fail_en, .cmd_done, .cmd_fail, .cmd_left);
   always #10 ref_clk = ~ref_clk;
   // The tests need well under a thousand cycles.
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      started = started | cmd_start;
      if (cycles == 3000) begin
         fail_count = fail_count + 1;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string nm, input [16:0] seen, input [16:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One access; read data is taken the cycle after the strobe.
   task acc(input w, input [3:0] a, input [7:0] v);
      @(negedge ref_clk);
      {host_wr, host_rd, host_addr, host_wdata} = {w, !w, a, v};
      @(negedge ref_clk);
      {host_wr, host_rd} = 2'h0;
      d = host_rdata;
   endtask
   task rd(input [3:0] a); acc(1'b0, a, 8'h00); endtask
   task wr(input [3:0] a, input [7:0] v); acc(1'b1, a, v); endtask
   // Bounded wait: refused commands never see the back end end.
   task run(input [7:0] op, input go);
      started = 1'b0;
      if (go) wr(4'h7, op);
      for (i = 0; i < 12 && !cmd_done; i = i + 1)
         @(negedge ref_clk);
      @(negedge ref_clk);
   endtask
   initial begin
      repeat (12) @(negedge ref_clk);
      reset_n = 1'b1;
      rd(4'h7);
      chk("ready", d[6], 1'b0);
      init_done = 1'b1;
      rd(4'h7);
      rd(4'h7);
      chk("idle", {d[7:6], d[2]}, 3'h2);
      wr(4'h2, 8'h00);
      wr(4'h7, 8'h20);
      rd(4'h2);
      chk("busy", d, 8'h80);
      chk("sect28", cmd_sectors, 17'h0_0100);
      wr(4'h3, 8'h55);
      xfer_ready = 1'b1;
      rd(4'h7);
      xfer_ready = 1'b0;
      chk("drq", d, 8'h48);
      run(8'h00, 1'b0);
      chk("irq", host_interrupt, 1'b1);
      rd(4'h7);
      chk("ack", {host_interrupt, d[0]}, 2'h0);
      rd(4'h2);
      chk("count", d, 8'h00);
      rd(4'h3);
      chk("wr_busy", d, 8'h00);
      fail_en = 1'b1;
      wr(4'h2, 8'h00);
      run(8'h24, 1'b1);
      fail_en = 1'b0;
      chk("sect48", cmd_sectors, 17'h1_0000);
      rd(4'h2);
      chk("left", d, 8'h03);
      rd(4'h1);
      chk("abort", d[2], 1'b1);
      rd(4'h7);
      chk("failed", d[0], 1'b1);
      run(8'h01, 1'b1);
      seek_end = 1'b1;
      @(negedge ref_clk);
      seek_end = 1'b0;
      rd(4'h7);
      chk("bad_op", {started, d[4], d[0]}, 3'h1);
      wr(4'h1, 8'hD0);
      run(8'hB0, 1'b1);
      rd(4'h7);
      chk("subcode", {started, cmd_feature, d[0]}, 10'h3A0);
      $display("test commands done");
      {write_fault, index_mark, seek_begin} = 3'h7;
      @(negedge ref_clk);
      {write_fault, index_mark, seek_begin} = 3'h0;
      rd(4'h7);
      chk("fault", d[5:4], 2'h2);
      seek_end = 1'b1;
      rd(4'h7);
      seek_end = 1'b0;
      chk("fault_clr", d[5:4], 2'h1);
      {seek_begin, index_mark} = 2'h3;
      rd(4'h7);
      {seek_begin, index_mark} = 2'h0;
      chk("seek_idx", {d[4], d[1]}, 2'h1);
      power_save = 1'b1;
      rd(4'h7);
      power_save = 1'b0;
      chk("standby", d[4], 1'b1);
      wr(4'hE, 8'h02);
      run(8'hEC, 1'b1);
      chk("masked", host_interrupt, 1'b0);
      wr(4'hE, 8'h00);
      wr(4'h6, 8'h10);
      chk("other_dev", host_interrupt, 1'b0);
      wr(4'h6, 8'h00);
      chk("selected", host_interrupt, 1'b1);
      wr(4'hE, 8'h04);
      rd(4'h3);
      chk("soft_reset", d, 8'h80);
      wr(4'hE, 8'h00);
      rd(4'h7);
      chk("resumed", d[7], 1'b0);
      $display("test flags done");
      user_pw_saved = 1'b1;
      reset_n = 1'b0;
      repeat (12) @(negedge ref_clk);
      reset_n = 1'b1;
      rd(4'h7);
      run(8'h20, 1'b1);
      rd(4'h7);
      chk("locked", {sec_locked, started, d[0]}, 3'h5);
      // A wrong master password first, then the shipped one.
      for (p = 0; p < 2; p = p + 1) begin
         for (i = 0; i < 17; i = i + 1) begin
            @(negedge ref_clk);
            {pw_we, pw_index} = {1'b1, i[4:0]};
            pw_word = i == 0 ? 16'h0001 : p ? 16'h2020 : 16'h2121;
         end
         @(negedge ref_clk);
         pw_we = 1'b0;
         run(8'hF2, 1'b1);
         chk("unlock", sec_locked, p == 0);
      end
      run(8'h20, 1'b1);
      chk("opened", started, 1'b1);
      $display("test security done");
      close_out;
   end
endmodule
bind ats_task_file ats_chk ats_chk_inst (.ref_clk, .reset_n, .host_wr,
   .host_rd, .host_addr, .host_wdata, .host_rdata, .host_interrupt,
   .cmd_start, .cmd_opcode, .cmd_done, .user_pw_saved, .sec_locked);

/* rtl/ats_defines.vh */
`ifndef ATS_DEFINES_VH
`define ATS_DEFINES_VH

// ----------------------------------------------------------------------
// Host register select codes on host_addr.
// ----------------------------------------------------------------------
`define ATS_REG_ERROR 4'h1
`define ATS_REG_FEATURE 4'h1
`define ATS_REG_COUNT 4'h2
`define ATS_REG_LBA_LOW 4'h3
`define ATS_REG_DEVICE 4'h6
`define ATS_REG_STATUS 4'h7
`define ATS_REG_COMMAND 4'h7
`define ATS_REG_CONTROL 4'hE

// ----------------------------------------------------------------------
// Status byte bit positions.
// ----------------------------------------------------------------------
`define ATS_ST_BUSY 7
`define ATS_ST_READY 6
`define ATS_ST_FAULT 5
`define ATS_ST_SEEK 4
`define ATS_ST_DREQ 3
`define ATS_ST_CORRECTED 2
`define ATS_ST_INDEX 1
`define ATS_ST_ERR 0

// ----------------------------------------------------------------------
// Other field positions and reset values.
// ----------------------------------------------------------------------
`define ATS_ERR_ABORT 2
`define ATS_CTL_HOB 7
`define ATS_CTL_SOFT_RESET 2
`define ATS_CTL_IRQ_DIS 1
`define ATS_DEV_SEL 4
`define ATS_PW_ID_BIT 0
`define ATS_PW_LEVEL_BIT 8
`define ATS_MASTER_PW_WORD 16'h2020
`define ATS_BYTE_ZERO 8'h00
`define ATS_SECT_MAX28 17'h0_0100
`define ATS_SECT_MAX48 17'h1_0000

// ----------------------------------------------------------------------
// Security command opcodes.
// ----------------------------------------------------------------------
`define ATS_OP_SEC_SET 8'hF1
`define ATS_OP_SEC_UNLOCK 8'hF2
`define ATS_OP_SEC_ERASE 8'hF4
`define ATS_OP_SEC_DISABLE 8'hF6

`endif

/* rtl/ats_security.v */
`timescale 1ns/1ps
`include "ats_defines.vh"

// ----------------------------------------------------------------------
// Password store and lock state for the security feature set.
// ----------------------------------------------------------------------
module ats_security (
   input wire ref_clk,
   input wire reset_n,
   input wire pw_we,
   input wire [4:0] pw_index,
   input wire [15:0] pw_word,
   input wire [7:0] op,
   input wire op_done,
   input wire user_pw_saved,
   output reg locked,
   output wire pw_ok,
   output reg user_pw_store
);

   reg [15:0] master_pw [0:15]; // Master password words.
   reg [15:0] user_pw [0:15]; // User password words.
   reg [15:0] ctl_word; // Word 0 of the password block.
   reg hit_master; // All words so far match the master password.
   reg hit_user; // All words so far match the user password.
   reg level_max; // Maximum security level selected.
   reg boot; // First cycle after reset release.
   wire [4:0] slot; // Password word index, zero based.
   wire use_master; // The block names the master password.
   integer i;

   assign slot = pw_index - 5'd1;
   assign use_master = ctl_word[`ATS_PW_ID_BIT];

   // Verdict on the password block for the running command.
   // A non-security opcode always passes.
   assign pw_ok = (op == `ATS_OP_SEC_UNLOCK) ?
         (use_master ? (hit_master & ~level_max) : hit_user) :
      (op == `ATS_OP_SEC_ERASE) ?
         (use_master ? hit_master : (hit_user & ~level_max)) :
      (op == `ATS_OP_SEC_DISABLE) ?
         (use_master ? (hit_master & ~level_max) : hit_user) :
      1'b1;

   // ----------------------------------------------------------------------
   // Password capture, comparison and lock state.
   // ----------------------------------------------------------------------
   // The lock level is caught one cycle after reset release, since a
   // flip-flop under reset may only take a constant.
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         locked <= 1'b0;
         boot <= 1'b1;
         level_max <= 1'b0;
         user_pw_store <= 1'b0;
         ctl_word <= 16'h0000;
         hit_master <= 1'b1;
         hit_user <= 1'b1;
         for (i = 0; i < 16; i = i + 1) begin
            master_pw[i] <= `ATS_MASTER_PW_WORD;
            user_pw[i] <= 16'h0000;
         end
      end else begin
         if (boot) begin
            boot <= 1'b0;
            locked <= user_pw_saved;
            user_pw_store <= user_pw_saved;
         end
         if (pw_we) begin
            if (pw_index == 5'd0) begin
               ctl_word <= pw_word;
               hit_master <= 1'b1;
               hit_user <= 1'b1;
            end else if (pw_index <= 5'd16) begin
               hit_master <= hit_master & (pw_word == master_pw[slot[3:0]]);
               hit_user <= hit_user & (pw_word == user_pw[slot[3:0]]);
               // Words are written as they stream in during a set.
               if (op == `ATS_OP_SEC_SET) begin
                  if (use_master) begin
                     master_pw[slot[3:0]] <= pw_word;
                  end else begin
                     user_pw[slot[3:0]] <= pw_word;
                  end
               end
            end
         end
         if (op_done & pw_ok) begin
            case (op)
               `ATS_OP_SEC_SET: begin
                  // A new master leaves the lock alone; a user one arms
                  // it for the next power-on only.
                  if (!use_master) begin
                     user_pw_store <= 1'b1;
                     level_max <= ctl_word[`ATS_PW_LEVEL_BIT];
                  end
               end
               `ATS_OP_SEC_UNLOCK: begin
                  locked <= 1'b0;
               end
               `ATS_OP_SEC_ERASE: begin
                  locked <= 1'b0;
                  user_pw_store <= 1'b0;
               end
               `ATS_OP_SEC_DISABLE: begin
                  locked <= 1'b0;
                  user_pw_store <= 1'b0;
               end
               default: begin
                  locked <= locked;
               end
            endcase
         end
      end
   end

endmodule

/* rtl/ats_task_file.v */
`timescale 1ns/1ps
`include "ats_defines.vh"

module ats_task_file #(
   parameter DEV_ID = 1'b0
) (
   input wire ref_clk,
   input wire reset_n,
   input wire host_wr,
   input wire host_rd,
   input wire [3:0] host_addr,
   input wire [7:0] host_wdata,
   output reg [7:0] host_rdata,
   output wire host_interrupt,
   output reg cmd_start,
   output reg [7:0] cmd_opcode,
   output reg [7:0] cmd_feature,
   output reg [16:0] cmd_sectors,
   input wire cmd_done,
   input wire cmd_fail,
   input wire [15:0] cmd_left,
   input wire init_done,
   input wire write_fault,
   input wire seek_begin,
   input wire seek_end,
   input wire power_save,
   input wire xfer_ready,
   input wire index_mark,
   input wire pw_we,
   input wire [4:0] pw_index,
   input wire [15:0] pw_word,
   input wire user_pw_saved,
   output wire user_pw_store,
   output wire sec_locked
);

   // ----------------------------------------------------------------------
   // Command engine states.
   // ----------------------------------------------------------------------
   localparam ST_IDLE = 3'b001; // Waiting for a command.
   localparam ST_EXEC = 3'b010; // Back end owns the command.
   localparam ST_SOFT = 3'b100; // Held by the soft reset bit.

   reg [2:0] state; // One-hot engine state.
   reg [7:0] count_cur; // Sector count, most recent byte.
   reg [7:0] count_prev; // Sector count, previous byte.
   reg [7:0] feature; // Feature register.
   reg [7:0] lba_low; // Address low byte.
   reg [7:0] dev_head; // Device and head register.
   reg [7:0] error_reg; // Error register.
   reg hob; // Read back the previous bytes.
   reg soft_reset_bit; // Host soft reset.
   reg irq_disable_bit; // Host interrupt disable.
   reg ready_flag; // Device can take commands.
   reg write_fault_flag; // Sticky write fault.
   reg seek_done_flag; // Seek complete.
   reg seek_frozen; // Seek flag held after an error.
   reg error_flag; // Previous command failed.
   reg index_pulse_flag; // Index mark seen last cycle.
   reg irq_pending; // Interrupt waiting for acknowledge.
   reg [7:0] next_rdata; // Read data chosen for this access.
   wire busy_flag; // Device owns the registers.
   wire data_request_flag; // Data phase ready.
   wire corrected_flag; // Never set.
   wire [7:0] status_byte; // Assembled status.
   wire rd_status; // Host reads the status register.
   wire tf_wr; // Accepted write to a task-file register.
   wire cmd_wr; // Accepted write of a command.
   wire cmd_ok; // Opcode accepted for execution.
   wire pw_ok; // Password verdict for the running command.
   wire finish; // Back end ends the command.
   wire fail; // Command ends in failure.
   wire cmd_ext; // Opcode uses 48-bit addressing.

   // ----------------------------------------------------------------------
   // Opcode decoding.
   // ----------------------------------------------------------------------
   // Supported opcode set, with subcode checks for the paired codes.
   function ats_valid;
      input [7:0] op;
      input [7:0] sub;
      begin
         case (op)
            8'hB0: ats_valid = (sub >= 8'hD0) && (sub <= 8'hDB) &&
               (sub != 8'hD7);
            8'hB1: ats_valid = (sub >= 8'hC0) && (sub <= 8'hC3);
            8'hF9: ats_valid = (sub <= 8'h04);
            8'hE5, 8'h98, 8'h70, 8'hEF, 8'h37, 8'h92, 8'h90, 8'hE7,
            8'hC6, 8'hEA, 8'hEC, 8'hE6, 8'h99, 8'hE3, 8'h97, 8'hE1,
            8'h95, 8'h91, 8'hE4, 8'h25, 8'hC8, 8'hC9, 8'h2F, 8'hC4,
            8'h29, 8'hF8, 8'h27, 8'hE2, 8'h96, 8'h24, 8'hE0, 8'h94,
            8'h20, 8'hE8, 8'h21, 8'h35, 8'h42, 8'hCA, 8'h40, 8'hCB,
            8'h41, 8'h3F, 8'hC5, 8'h39, 8'hF3, 8'h34, 8'hF4, 8'h30,
            8'hF5, 8'h31, 8'hF1, 8'hF2, 8'hF6: ats_valid = 1'b1;
            default: ats_valid = 1'b0;
         endcase
      end
   endfunction

   // Commands that address the media; refused while locked.
   function ats_media;
      input [7:0] op;
      begin
         case (op)
            8'h20, 8'h21, 8'h24, 8'h25, 8'h29, 8'h30, 8'h31, 8'h34,
            8'h35, 8'h39, 8'h40, 8'h41, 8'h42, 8'h70, 8'hC4, 8'hC5,
            8'hC8, 8'hC9, 8'hCA, 8'hCB: ats_media = 1'b1;
            default: ats_media = 1'b0;
         endcase
      end
   endfunction

   // Commands with 48-bit addressing and a 16-bit count.
   function ats_ext;
      input [7:0] op;
      begin
         case (op)
            8'h24, 8'h25, 8'h27, 8'h29, 8'h2F, 8'h34, 8'h35, 8'h37,
            8'h39, 8'h3F, 8'h42: ats_ext = 1'b1;
            default: ats_ext = 1'b0;
         endcase
      end
   endfunction

   // Expands the count; zero stands for the largest count.
   function [16:0] ats_count;
      input ext;
      input [7:0] hi;
      input [7:0] lo;
      begin
         if (ext) begin
            ats_count = ({hi, lo} == 16'h0000) ? `ATS_SECT_MAX48 :
               {1'b0, hi, lo};
         end else begin
            ats_count = (lo == `ATS_BYTE_ZERO) ? `ATS_SECT_MAX28 :
               {9'h000, lo};
         end
      end
   endfunction

   // ----------------------------------------------------------------------
   // Status and access qualification.
   // ----------------------------------------------------------------------
   // During the data phase busy drops so that data request can be seen.
   assign busy_flag = state[2] | (state[1] & ~xfer_ready);
   assign data_request_flag = state[1] & xfer_ready;
   assign corrected_flag = 1'b0;

   // The remaining bits are not valid while busy, so they read zero.
   assign status_byte = busy_flag ? 8'h80 : {
      1'b0,
      ready_flag,
      write_fault_flag,
      seek_done_flag,
      data_request_flag,
      corrected_flag,
      index_pulse_flag,
      error_flag};

   assign rd_status = host_rd & (host_addr == `ATS_REG_STATUS);
   // Task-file writes are dropped while busy; control stays open so the
   // soft reset can still be released.
   assign tf_wr = host_wr & ~busy_flag &
      (host_addr != `ATS_REG_CONTROL);
   // A command needs an idle engine and a ready device.
   assign cmd_wr = tf_wr & (host_addr == `ATS_REG_COMMAND) &
      state[0] & ready_flag;
   assign cmd_ok = ats_valid(host_wdata, feature) &
      ~(sec_locked & ats_media(host_wdata));
   assign cmd_ext = ats_ext(host_wdata);
   assign finish = state[1] & cmd_done;
   assign fail = cmd_fail | ~pw_ok;

   // Interrupt is gated by enable and device select.
   assign host_interrupt = irq_pending & ~irq_disable_bit &
      (dev_head[`ATS_DEV_SEL] == DEV_ID);

   // ----------------------------------------------------------------------
   // Host read path.
   // ----------------------------------------------------------------------
   // Any read while busy returns the status byte.
   always @* begin
      next_rdata = `ATS_BYTE_ZERO;
      if (busy_flag) begin
         next_rdata = status_byte;
      end else begin
         case (host_addr)
            `ATS_REG_ERROR: next_rdata = error_reg;
            `ATS_REG_COUNT: next_rdata = hob ? count_prev : count_cur;
            `ATS_REG_LBA_LOW: next_rdata = lba_low;
            `ATS_REG_DEVICE: next_rdata = dev_head;
            `ATS_REG_STATUS: next_rdata = status_byte;
            `ATS_REG_CONTROL: next_rdata = status_byte;
            default: next_rdata = `ATS_BYTE_ZERO;
         endcase
      end
   end

   // Read data is registered and holds until the next read.
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         host_rdata <= `ATS_BYTE_ZERO;
      end else if (host_rd) begin
         host_rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------------
   // Status flags.
   // ----------------------------------------------------------------------
   // Clears from a status read come first so that a set in the same
   // cycle wins and no event is lost.
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         ready_flag <= 1'b0;
         write_fault_flag <= 1'b0;
         seek_done_flag <= 1'b0;
         seek_frozen <= 1'b0;
         index_pulse_flag <= 1'b0;
      end else begin
         ready_flag <= ready_flag | init_done;
         index_pulse_flag <= index_mark;
         if (rd_status) begin
            write_fault_flag <= 1'b0;
            seek_frozen <= 1'b0;
         end
         if (write_fault) begin
            write_fault_flag <= 1'b1;
         end
         if ((finish & fail) | (cmd_wr & ~cmd_ok)) begin
            seek_frozen <= 1'b1;
         end
         // Power save overrides the freeze; otherwise the flag follows
         // the seek only while not frozen or on the releasing read.
         if (power_save) begin
            seek_done_flag <= 1'b1;
         end else if (~seek_frozen | rd_status) begin
            if (seek_end) begin
               seek_done_flag <= 1'b1;
            end else if (seek_begin) begin
               seek_done_flag <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers, command engine and completion.
   // ----------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         count_cur <= `ATS_BYTE_ZERO;
         count_prev <= `ATS_BYTE_ZERO;
         feature <= `ATS_BYTE_ZERO;
         lba_low <= `ATS_BYTE_ZERO;
         dev_head <= `ATS_BYTE_ZERO;
         error_reg <= `ATS_BYTE_ZERO;
         hob <= 1'b0;
         soft_reset_bit <= 1'b0;
         irq_disable_bit <= 1'b0;
         error_flag <= 1'b0;
         irq_pending <= 1'b0;
         cmd_start <= 1'b0;
         cmd_opcode <= `ATS_BYTE_ZERO;
         cmd_feature <= `ATS_BYTE_ZERO;
         cmd_sectors <= 17'h0_0000;
      end else begin
         cmd_start <= 1'b0;
         if (rd_status) begin
            irq_pending <= 1'b0;
         end
         if (host_wr & (host_addr == `ATS_REG_CONTROL)) begin
            hob <= host_wdata[`ATS_CTL_HOB];
            soft_reset_bit <= host_wdata[`ATS_CTL_SOFT_RESET];
            irq_disable_bit <= host_wdata[`ATS_CTL_IRQ_DIS];
         end
         if (tf_wr) begin
            hob <= 1'b0;
            case (host_addr)
               `ATS_REG_FEATURE: feature <= host_wdata;
               `ATS_REG_COUNT: begin
                  count_prev <= count_cur;
                  count_cur <= host_wdata;
               end
               `ATS_REG_LBA_LOW: lba_low <= host_wdata;
               `ATS_REG_DEVICE: dev_head <= host_wdata;
               default: hob <= 1'b0;
            endcase
         end
         if (cmd_wr) begin
            error_flag <= 1'b0;
            error_reg <= `ATS_BYTE_ZERO;
            if (cmd_ok) begin
               state <= ST_EXEC;
               cmd_start <= 1'b1;
               cmd_opcode <= host_wdata;
               cmd_feature <= feature;
               cmd_sectors <= ats_count(cmd_ext, count_prev, count_cur);
            end else begin
               // Refused at once; status is refreshed with the error.
               error_flag <= 1'b1;
               error_reg[`ATS_ERR_ABORT] <= 1'b1;
               irq_pending <= 1'b1;
            end
         end
         if (finish) begin
            state <= ST_IDLE;
            irq_pending <= 1'b1;
            if (fail) begin
               error_flag <= 1'b1;
               error_reg[`ATS_ERR_ABORT] <= 1'b1;
               count_cur <= cmd_left[7:0];
               count_prev <= cmd_left[15:8];
            end else begin
               count_cur <= `ATS_BYTE_ZERO;
               count_prev <= `ATS_BYTE_ZERO;
            end
         end
         // Soft reset abandons any command and overrides the state and pending interrupt.
         if (soft_reset_bit) begin
            state <= ST_SOFT;
            irq_pending <= 1'b0;
         end else if (state[2]) begin
            state <= ST_IDLE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Security lock and password store.
   // ----------------------------------------------------------------------
   ats_security ats_security_inst (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pw_we(pw_we),
      .pw_index(pw_index),
      .pw_word(pw_word),
      .op(cmd_opcode),
      .op_done(finish & ~cmd_fail),
      .user_pw_saved(user_pw_saved),
      .locked(sec_locked),
      .pw_ok(pw_ok),
      .user_pw_store(user_pw_store)
   );

endmodule
